// File: design/adcrc_core.sv
// Scan sequencer, calibration store, result memory and APB registers.
`timescale 1ns/100ps
`include "adcrc_cfg.svh"
// Summary of operation
// - Averaging needs four scans before results valid
// - Averaging scan lasts 5 ms or 4.167 ms
// - Averaging scans always convert all eight channels
// - Without averaging only active channels, faster rate
// - Offset request stores next conversion as offset
// - Positive request stores next conversion as gain
// - Negative request stores next conversion as gain
// - Finished calibration clears the pending request
// - Over-range when corrected value exceeds positive gain
// - Unipolar under-range on negative corrected value
// - Bipolar under-range below negative gain
// - Bipolar two's complement or offset binary; unipolar binary
// - Bipolar codes 7FFF/FFFF, 8000/0000, 0000/8000
// - Unipolar codes 0000 to FFFF, midpoint 8000
// - Over-range clamps to maximum code
// - Under-range clamps to minimum code
// - Default coefficients give uncalibrated output
// - Calibration flag raised only by active channels
// - Suppress bit withholds scan interrupt during calibration
module adcrc_core import adcrc_pkg::*; #(
	parameter int SLOT50_CYC = `ADCRC_SCAN50_NS / `ADCRC_NUM_LCH / `ADCRC_CLK_NS,
	parameter int SLOT60_CYC = `ADCRC_SCAN60_NS / `ADCRC_NUM_LCH / `ADCRC_CLK_NS,
	parameter int SLOTOFF_CYC = `ADCRC_SLOT_OFF_NS / `ADCRC_CLK_NS
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Conversion slot towards the multiplexer and filters.
	output logic conv_start,
	output logic [2:0] conv_logical,
	output logic [2:0] conv_physical,
	output logic conv_bipolar,
	// Filtered conversion word of the current slot.
	input wire logic filt_valid,
	input wire adcrc_word_t filt_data,
	// Status pins.
	output logic end_of_scan_irq,
	output logic calibration_active_out
);
	// ==========================================================
	// Storage.
	logic [`ADCRC_CTRL_W-1:0] ctrl_q, ctrl_d; // Chip level control.
	logic [`ADCRC_CCB_W-1:0] ccb_q [8]; // Channel configuration bytes.
	logic [`ADCRC_CCB_W-1:0] ccb_d [8];
	adcrc_word_t off_q [8], off_d [8]; // Offset memory, per physical channel.
	adcrc_word_t pg_q [8], pg_d [8]; // Positive slope memory.
	adcrc_word_t ng_q [8], ng_d [8]; // Negative slope memory.
	logic [17:0] res_q [8], res_d [8]; // Result with under and over flags.
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	// Sequencer state.
	logic [15:0] cnt_q, cnt_d; // Cycle within the slot.
	logic [2:0] ch_q, ch_d; // Logical channel being converted.
	logic [2:0] fill_q, fill_d; // Averaged scans completed since restart, saturating.
	adcrc_cal_t code_q, code_d; // Request caught at slot start.
	logic [2:0] sch_q, sch_d; // Logical channel of the caught slot.
	logic [2:0] phys_q, phys_d; // Physical channel of the caught slot.
	logic bip_q, bip_d; // Polarity of the caught slot.
	logic start_q, start_d;
	logic scan_irq_q, scan_irq_d;
	logic cal_act_q, cal_act_d;

	// ==========================================================
	// Bus decode.
	logic setup, wr_done, rd_done, restart, scan_end;
	logic [2:0] rgn, idx;
	logic [15:0] slot_len;
	logic [2:0] last_ch;
	// Math results for the caught slot.
	logic signed [24:0] diff;
	logic [15:0] code;
	logic over, under;

	// True when the address points into one region.
	function automatic logic in_rgn(input logic [7:0] a, input logic [2:0] r);
		in_rgn = a[7:5] == r;
	endfunction

	assign rgn = paddr[7:5];
	assign idx = paddr[4:2];
	assign setup = psel && !penable;
	// The answer comes in the first access cycle, so each transfer is
	// exactly one setup and one access cycle.
	assign wr_done = psel && penable && pready_q && pwrite;
	assign rd_done = psel && penable && pready_q && !pwrite;
	// Changing the line-noise timing restarts the scan so the averaging
	// filters never mix samples taken at two different rates.
	assign restart = wr_done && in_rgn(paddr, `ADCRC_RGN_CTL) && idx == `ADCRC_IDX_CTRL
		&& (pwdata[`ADCRC_CTRL_AVG] != ctrl_q[`ADCRC_CTRL_AVG]
		|| pwdata[`ADCRC_CTRL_SEL60] != ctrl_q[`ADCRC_CTRL_SEL60]);
	// Slot length follows the selected line rate when averaging; without averaging it is the fixed plain slot.
	assign slot_len = !ctrl_q[`ADCRC_CTRL_AVG] ? 16'(SLOTOFF_CYC) :
		(ctrl_q[`ADCRC_CTRL_SEL60] ? 16'(SLOT60_CYC) : 16'(SLOT50_CYC));
	assign last_ch = ctrl_q[`ADCRC_CTRL_AVG] ? `ADCRC_LAST_LCH :
		ctrl_q[`ADCRC_CTRL_NACT];
	assign scan_end = (cnt_q == slot_len - 16'h1) && (ch_q >= last_ch);

	// ==========================================================
	// Calibration arithmetic for the slot that is being converted.
	adcrc_cal_math u_math (
		.raw(filt_data),
		.offset(off_q[phys_q]),
		.pgain(pg_q[phys_q]),
		.ngain(ng_q[phys_q]),
		.bipolar(bip_q),
		.twos(ctrl_q[`ADCRC_CTRL_TWOS]),
		.diff(diff),
		.code(code),
		.over(over),
		.under(under)
	);

	// ==========================================================
	// Sequencer next state: slots, scans, averaging fill and status pins.
	always_comb begin
		cnt_d = cnt_q + 16'h1;
		ch_d = ch_q;
		fill_d = fill_q;
		code_d = code_q;
		sch_d = sch_q;
		phys_d = phys_q;
		bip_d = bip_q;
		start_d = 1'b0;
		cal_act_d = 1'b0;
		scan_irq_d = scan_irq_q;
		// Only channels inside the active count may raise the flag.
		for (int i = 0; i < `ADCRC_NUM_LCH; i++) begin
			if (3'(i) <= ctrl_q[`ADCRC_CTRL_NACT]
				&& ccb_q[i][`ADCRC_CCB_CAL] != ADCRC_CAL_NONE) begin
				cal_act_d = 1'b1;
			end
		end
		if (cnt_q == 16'h0) begin
			// A request written later in the slot waits for the next one.
			code_d = adcrc_cal_t'(ccb_q[ch_q][`ADCRC_CCB_CAL]);
			sch_d = ch_q;
			phys_d = ccb_q[ch_q][`ADCRC_CCB_PHYS];
			bip_d = ccb_q[ch_q][`ADCRC_CCB_BIP];
			start_d = 1'b1;
		end
		if (cnt_q == slot_len - 16'h1) begin
			cnt_d = 16'h0;
			// Shrinking the active count mid-scan wraps at once instead of
			// running on through channels that are no longer active.
			ch_d = (ch_q >= last_ch) ? 3'h0 : ch_q + 3'h1;
		end
		// Reading status acknowledges the scan interrupt.
		if (rd_done && in_rgn(paddr, `ADCRC_RGN_CTL) && idx == `ADCRC_IDX_STAT) begin
			scan_irq_d = 1'b0;
		end
		if (scan_end) begin
			if (ctrl_q[`ADCRC_CTRL_AVG] && fill_q != `ADCRC_FILL_SCANS) begin
				fill_d = fill_q + 3'h1;
			end
			// A scan end in the acknowledge cycle still sets the flag.
			if ((!ctrl_q[`ADCRC_CTRL_AVG] || fill_d == `ADCRC_FILL_SCANS)
				&& !(ctrl_q[`ADCRC_CTRL_SUPP] && cal_act_q)) begin
				scan_irq_d = 1'b1;
			end
		end
		if (restart) begin
			cnt_d = 16'h0;
			ch_d = 3'h0;
			fill_d = 3'h0;
			scan_irq_d = 1'b0;
		end
	end

	// Sequencer registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 16'h0;
			ch_q <= 3'h0;
			fill_q <= 3'h0;
			code_q <= ADCRC_CAL_NONE;
			sch_q <= 3'h0;
			phys_q <= 3'h0;
			bip_q <= 1'b0;
			start_q <= 1'b0;
			scan_irq_q <= 1'b0;
			cal_act_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			ch_q <= ch_d;
			fill_q <= fill_d;
			code_q <= code_d;
			sch_q <= sch_d;
			phys_q <= phys_d;
			bip_q <= bip_d;
			start_q <= start_d;
			scan_irq_q <= scan_irq_d;
			cal_act_q <= cal_act_d;
		end
	end

	// ==========================================================
	// Register file next state: hardware updates first, then bus writes.
	// A bus write in the same cycle wins, so a request written in the clearing cycle is not lost; one written earlier in the slot is cleared.
	always_comb begin
		ctrl_d = ctrl_q;
		ccb_d = ccb_q;
		off_d = off_q;
		pg_d = pg_q;
		ng_d = ng_q;
		res_d = res_q;
		if (filt_valid) begin
			unique case (code_q)
				ADCRC_CAL_NONE: res_d[sch_q] = {under, over, code};
				ADCRC_CAL_OFF: off_d[phys_q] = filt_data;
				ADCRC_CAL_PFS: pg_d[phys_q] = diff[23:0];
				ADCRC_CAL_NFS: ng_d[phys_q] = 24'(-diff);
			endcase
			if (code_q != ADCRC_CAL_NONE) begin
				ccb_d[sch_q][`ADCRC_CCB_CAL] = ADCRC_CAL_NONE;
			end
		end
		if (wr_done) begin
			unique case (rgn)
				`ADCRC_RGN_CTL: begin
					if (idx == `ADCRC_IDX_CTRL) begin
						ctrl_d = pwdata[`ADCRC_CTRL_W-1:0];
					end
				end
				`ADCRC_RGN_CCB: ccb_d[idx] = pwdata[`ADCRC_CCB_W-1:0];
				`ADCRC_RGN_OFF: off_d[idx] = pwdata[23:0];
				`ADCRC_RGN_PFS: pg_d[idx] = pwdata[23:0];
				`ADCRC_RGN_NFS: ng_d[idx] = pwdata[23:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Bus answer: read data is fetched during setup and shown with ready
	// in the first access cycle. Unmapped reads return zero with error.
	always_comb begin
		pready_d = setup;
		pslverr_d = 1'b0;
		prdata_d = 32'h0;
		if (setup) begin
			unique case (rgn)
				`ADCRC_RGN_CTL: begin
					if (idx == `ADCRC_IDX_CTRL) begin
						prdata_d = 32'(ctrl_q);
					end else if (idx == `ADCRC_IDX_STAT) begin
						prdata_d[`ADCRC_STAT_SCAN] = scan_irq_q;
						prdata_d[`ADCRC_STAT_CAL] = cal_act_q;
						prdata_d[`ADCRC_STAT_FULL] = fill_q == `ADCRC_FILL_SCANS;
						prdata_d[`ADCRC_STAT_CH] = ch_q;
					end else begin
						pslverr_d = 1'b1;
					end
				end
				`ADCRC_RGN_CCB: prdata_d = 32'(ccb_q[idx]);
				`ADCRC_RGN_OFF: prdata_d = 32'(off_q[idx]);
				`ADCRC_RGN_PFS: prdata_d = 32'(pg_q[idx]);
				`ADCRC_RGN_NFS: prdata_d = 32'(ng_q[idx]);
				`ADCRC_RGN_RES: begin
					// Results are read only; a write here is flagged.
					prdata_d = 32'(res_q[idx]);
					pslverr_d = pwrite;
				end
				default: pslverr_d = 1'b1;
			endcase
		end
	end

	// Register file and bus answer registers.
	// Coefficients reset to the uncalibrated transfer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `ADCRC_CTRL_RST;
			for (int i = 0; i < `ADCRC_NUM_LCH; i++) begin
				ccb_q[i] <= `ADCRC_CCB_RST;
				off_q[i] <= `ADCRC_OFF_RST;
				pg_q[i] <= `ADCRC_GAIN_RST;
				ng_q[i] <= `ADCRC_GAIN_RST;
				res_q[i] <= 18'h0;
			end
			prdata_q <= 32'h0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			ccb_q <= ccb_d;
			off_q <= off_d;
			pg_q <= pg_d;
			ng_q <= ng_d;
			res_q <= res_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// ==========================================================
	// Outputs, each straight from a flip-flop.
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign conv_start = start_q;
	assign conv_logical = sch_q;
	assign conv_physical = phys_q;
	assign conv_bipolar = bip_q;
	assign end_of_scan_irq = scan_irq_q;
	assign calibration_active_out = cal_act_q;
endmodule

// File: design/adcrc_cfg.svh
// Constants for the converter calibration, range and coding stage.
`ifndef ADCRC_CFG_SVH
`define ADCRC_CFG_SVH
// ==========================================================
// Timing.
`define ADCRC_CLK_NS 40
`define ADCRC_SCAN50_NS 5000000
`define ADCRC_SCAN60_NS 4167000
`define ADCRC_SLOT_OFF_NS 480300
`define ADCRC_NUM_LCH 8
`define ADCRC_LAST_LCH 3'h7
`define ADCRC_FILL_SCANS 3'h4
// ==========================================================
// Register regions, selected by paddr[7:5]; the word index is paddr[4:2].
`define ADCRC_RGN_CTL 3'h0
`define ADCRC_RGN_CCB 3'h1
`define ADCRC_RGN_OFF 3'h2
`define ADCRC_RGN_PFS 3'h3
`define ADCRC_RGN_NFS 3'h4
`define ADCRC_RGN_RES 3'h5
`define ADCRC_IDX_CTRL 3'h0
`define ADCRC_IDX_STAT 3'h1
// ==========================================================
// Control fields.
`define ADCRC_CTRL_AVG 0
`define ADCRC_CTRL_SEL60 1
`define ADCRC_CTRL_TWOS 2
`define ADCRC_CTRL_SUPP 3
`define ADCRC_CTRL_NACT 6:4
`define ADCRC_CTRL_W 7
`define ADCRC_CTRL_RST 7'h70
// Channel configuration byte fields.
`define ADCRC_CCB_CAL 1:0
`define ADCRC_CCB_BIP 2
`define ADCRC_CCB_PHYS 6:4
`define ADCRC_CCB_W 7
`define ADCRC_CCB_RST 7'h00
// Status fields.
`define ADCRC_STAT_SCAN 0
`define ADCRC_STAT_CAL 1
`define ADCRC_STAT_FULL 2
`define ADCRC_STAT_CH 6:4
// ==========================================================
// Calibration reset values give an uncalibrated transfer.
`define ADCRC_OFF_RST 24'h000000
`define ADCRC_GAIN_RST 24'h800000
// Output codes.
`define ADCRC_TWOS_MAX 16'h7fff
`define ADCRC_TWOS_MIN 16'h8000
`define ADCRC_BIN_MAX 16'hffff
`define ADCRC_BIN_MIN 16'h0000
`define ADCRC_SIGN_FLIP 16'h8000
`endif

// File: design/adcrc_pkg.sv
// Types shared by the calibration, range and coding stage.
package adcrc_pkg;
	// ==========================================================
	// Calibration request code held in each channel configuration byte.
	typedef enum logic [1:0] {
		ADCRC_CAL_NONE = 2'b00,
		ADCRC_CAL_OFF = 2'b01,
		ADCRC_CAL_PFS = 2'b10,
		ADCRC_CAL_NFS = 2'b11
	} adcrc_cal_t;
	// One calibration coefficient or filter word.
	typedef logic [23:0] adcrc_word_t;
endpackage

// File: design/adcrc_cal_math.sv
// Offset correction, slope scaling, range detection and output coding.
`timescale 1ns/100ps
`include "adcrc_cfg.svh"
module adcrc_cal_math import adcrc_pkg::*; (
	// Filter word and coefficients of its physical channel.
	input wire adcrc_word_t raw,
	input wire adcrc_word_t offset,
	input wire adcrc_word_t pgain,
	input wire adcrc_word_t ngain,
	// Coding selection.
	input wire logic bipolar,
	input wire logic twos,
	// Results.
	output logic signed [24:0] diff,
	output logic [15:0] code,
	output logic over,
	output logic under
);
	// Magnitude of the offset-corrected value.
	logic [24:0] mag;
	// Slope coefficient picked by the sign of the difference.
	adcrc_word_t coef;
	// Scaled magnitude; unipolar spans 16 bits, bipolar 15 plus sign.
	logic [40:0] num;
	logic [40:0] quo;
	// Signed bipolar result before coding.
	logic [15:0] sres;

	// ==========================================================
	// Datapath.
	// A zero coefficient is treated as an infinite slope rather than
	// dividing by zero, so the result saturates instead of going unknown.
	always_comb begin
		diff = $signed({raw[23], raw}) - $signed({offset[23], offset});
		over = diff > $signed({1'b0, pgain});
		if (bipolar) begin
			under = diff < -$signed({1'b0, ngain});
		end else begin
			under = diff[24];
		end
		mag = diff[24] ? 25'(-diff) : diff;
		coef = diff[24] ? ngain : pgain;
		num = bipolar ? {1'b0, mag, 15'h0} : {mag, 16'h0};
		quo = (coef == '0) ? '1 : num / {17'h0, coef};
		sres = `ADCRC_BIN_MIN;
		if (over) begin
			code = (bipolar && twos) ? `ADCRC_TWOS_MAX : `ADCRC_BIN_MAX;
		end else if (under) begin
			code = (bipolar && twos) ? `ADCRC_TWOS_MIN : `ADCRC_BIN_MIN;
		end else if (!bipolar) begin
			// Straight binary from the zero point up to full scale.
			code = (quo > 41'(`ADCRC_BIN_MAX)) ? `ADCRC_BIN_MAX : quo[15:0];
		end else begin
			if (!diff[24]) begin
				sres = (quo > 41'(`ADCRC_TWOS_MAX)) ? `ADCRC_TWOS_MAX : quo[15:0];
			end else if (quo > 41'(`ADCRC_TWOS_MIN)) begin
				sres = `ADCRC_TWOS_MIN;
			end else begin
				sres = 16'(-quo[15:0]);
			end
			code = twos ? sres : (sres ^ `ADCRC_SIGN_FLIP);
		end
	end
endmodule

// File: verif/adcrc_core_asserts.sv
// Port checker for the calibration, range and coding core.
`timescale 1ns/100ps
module adcrc_core_asserts import adcrc_pkg::*; #(
	parameter int SLOT50_CYC = 20,
	parameter int SLOT60_CYC = 16,
	parameter int SLOTOFF_CYC = 12
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Register bus.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Slots, filter word and pins.
	input wire logic conv_start,
	input wire logic [2:0] conv_logical,
	input wire logic [2:0] conv_physical,
	input wire logic conv_bipolar,
	input wire logic filt_valid,
	input wire adcrc_word_t filt_data,
	input wire logic end_of_scan_irq,
	input wire logic calibration_active_out
);
	// ==========
	// Shadow state.
	logic [6:0] ctrl_q, ctrl_d; // Control word as last written.
	logic [2:0] last_q, last_d; // Channel of the previous slot.
	logic [1:0] ok_q, ok_d; // Slots seen since a control write.
	logic [3:0] scans_q, scans_d; // Scans begun since averaging restarted.
	int cnt_q, cnt_d; // Cycles since the last slot start.
	logic wr; // A control write completes.
	// Three slots after a control write go unchecked, since the sequencer may restart.
	always_comb begin
		wr = psel && penable && pready && pwrite && paddr == 8'h00;
		ctrl_d = wr ? pwdata[6:0] : ctrl_q;
		cnt_d = conv_start ? 1 : cnt_q + 1;
		last_d = conv_start ? conv_logical : last_q;
		ok_d = wr ? 2'h0 : ((conv_start && ok_q != 2'h3) ? ok_q + 2'h1 : ok_q);
		scans_d = scans_q;
		if (wr && pwdata[1:0] != ctrl_q[1:0]) begin
			scans_d = 4'h0;
		end else if (conv_start && conv_logical == 3'h0 && scans_q != 4'hf) begin
			scans_d = scans_q + 4'h1;
		end
	end
	// Registers only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= 7'h70;
			last_q <= 3'h0;
			ok_q <= 2'h0;
			scans_q <= 4'h0;
			cnt_q <= 0;
		end else begin
			ctrl_q <= ctrl_d;
			last_q <= last_d;
			ok_q <= ok_d;
			scans_q <= scans_d;
			cnt_q <= cnt_d;
		end
	end
	// ==========
	// Properties.
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	property p_ready;
		s_setup |=> s_access ##1 !pready;
	endproperty
	a_ready: assert property (p_ready) else $error("bus answer late or long");
	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_slot_lnr;
		conv_start && ok_q == 2'h3 && ctrl_q[0] |-> cnt_q == (ctrl_q[1] ? SLOT60_CYC : SLOT50_CYC);
	endproperty
	a_slot_lnr: assert property (p_slot_lnr) else $error("averaged slot length");
	property p_slot_off;
		conv_start && ok_q == 2'h3 && !ctrl_q[0] |-> cnt_q == SLOTOFF_CYC;
	endproperty
	a_slot_off: assert property (p_slot_off) else $error("plain slot length");
	property p_seq_lnr;
		conv_start && ok_q == 2'h3 && ctrl_q[0] |-> conv_logical == last_q + 3'h1;
	endproperty
	a_seq_lnr: assert property (p_seq_lnr) else $error("averaged scan order");
	property p_seq_act;
		conv_start && ok_q == 2'h3 && !ctrl_q[0]
			|-> conv_logical == (last_q >= ctrl_q[6:4] ? 3'h0 : last_q + 3'h1);
	endproperty
	a_seq_act: assert property (p_seq_act) else $error("active scan order");
	property p_fill;
		$rose(end_of_scan_irq) && ctrl_q[0] |-> scans_q >= 4'h4;
	endproperty
	a_fill: assert property (p_fill) else $error("scan end before filters full");
	property p_supp;
		$rose(end_of_scan_irq) |-> !(ctrl_q[3] && $past(calibration_active_out)
			&& calibration_active_out);
	endproperty
	a_supp: assert property (p_supp) else $error("scan end during calibration");
endmodule
bind adcrc_core adcrc_core_asserts #(.SLOT50_CYC(SLOT50_CYC), .SLOT60_CYC(SLOT60_CYC),
	.SLOTOFF_CYC(SLOTOFF_CYC)) i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .conv_start, .conv_logical, .conv_physical,
	.conv_bipolar, .filt_valid, .filt_data, .end_of_scan_irq, .calibration_active_out);

// File: verif/adcrc_filt_model.sv
// Filter-side model: answers every conversion slot with one filter word.
`timescale 1ns/100ps
module adcrc_filt_model import adcrc_pkg::*; (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Slot start, input level and answer delay.
	input wire logic conv_start,
	input wire adcrc_word_t level,
	input wire logic [3:0] delay,
	// Filter word.
	output logic filt_valid,
	output adcrc_word_t filt_data
);
	logic busy_q; // A slot awaits its word.
	logic [3:0] wait_q; // Cycles waited in this slot.
	// Outside the valid cycle the word toggles, so a stale value is never read as good.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			wait_q <= 4'h0;
			filt_valid <= 1'b0;
			filt_data <= 24'h0;
		end else begin
			filt_valid <= busy_q && wait_q == delay;
			filt_data <= (busy_q && wait_q == delay) ? level : ~filt_data;
			wait_q <= conv_start ? 4'h0 : wait_q + 4'h1;
			busy_q <= conv_start || (busy_q && wait_q != delay);
		end
	end
endmodule

// File: verif/adcrc_cal_range_coding_test.sv
// Self-checking bench for the calibration, range and coding core.
`timescale 1ns/100ps
module adcrc_cal_range_coding_test import adcrc_pkg::*; ();
	// ==========
	// Stimulus and observed signals.
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, conv_start, conv_bipolar, filt_valid;
	logic end_of_scan_irq, calibration_active_out;
	logic [2:0] conv_logical, conv_physical;
	adcrc_word_t filt_data, raw, level = 24'h0;
	logic [3:0] delay = 4'h2; // Filter answer delay, kept below the slot length.
	logic [64:0] note, notes[$]; // Expected {error, mask, data} per transfer.
	int mismatches = 0, total_checks = 0, cycles = 0, seed = 14156, rnd;
	initial forever #20 pclk = ~pclk;
	adcrc_core #(.SLOT50_CYC(20), .SLOT60_CYC(16), .SLOTOFF_CYC(12)) i_dut (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .conv_start,
		.conv_logical, .conv_physical, .conv_bipolar, .filt_valid, .filt_data,
		.end_of_scan_irq, .calibration_active_out);
	adcrc_filt_model i_far (.pclk, .presetn, .conv_start, .level, .delay, .filt_valid,
		.filt_data);
	// ==========
	// Shared tasks.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (exp !== got) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// One bus transfer; the answer is judged by the monitor below.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic e);
		notes.push_back({e, m, d & m});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d);
		apb(1'b0, a, d, 32'hffffffff, 1'b0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 32'h0, 1'b0);
	endtask
	task automatic slots(input int n);
		repeat (n) @(posedge pclk iff conv_start);
	endtask
	// Expected result word {under, over, code}.
	function automatic logic [17:0] calc(input adcrc_word_t r, input adcrc_word_t off,
		input adcrc_word_t g, input logic bip, input logic two);
		longint d;
		longint c;
		d = longint'($signed(r)) - longint'($signed(off));
		if (d > longint'(g)) begin
			return {2'b01, (bip && two) ? 16'h7fff : 16'hffff};
		end
		if (bip ? d < -longint'(g) : d < 0) begin
			return {2'b10, (bip && two) ? 16'h8000 : 16'h0000};
		end
		c = bip ? d * 32768 / longint'(g) : d * 65536 / longint'(g);
		// Exactly full scale lands one past the top code and is held there.
		if (c > (bip ? 32767 : 65535)) begin
			c = bip ? 32767 : 65535;
		end
		return {2'b00, c[15:0] ^ ((bip && !two) ? 16'h8000 : 16'h0000)};
	endfunction
	task automatic test_done();
		$display("checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ==========
	// Monitor: each completed transfer takes the oldest note.
	always @(posedge pclk) begin
		if (psel && penable && pready && notes.size() > 0) begin
			note = notes.pop_front();
			chk("read data", note[31:0], prdata & note[63:32]);
			chk("slave error", 32'(note[64]), 32'(pslverr));
		end
	end
	// A hang counts as a mismatch.
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			mismatches++;
			test_done();
		end
	end
	// ==========
	// Main sequence.
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(8'h00, 32'h70);
		rd(8'h80, 32'h800000);
		apb(1'b0, 8'hc0, 32'h0, 32'hffffffff, 1'b1);
		apb(1'b1, 8'ha0, 32'h1, 32'h0, 1'b1);
		level <= 24'h100000;
		wr(8'h20, 32'h04);
		slots(20);
		rd(8'ha0, 32'(calc(24'h100000, 24'h0, 24'h800000, 1'b1, 1'b0)));
		$display("defaults test done");
		// Zero scale first, then both gains, on logical 0 mapped to physical 2.
		delay <= 4'h8;
		wr(8'h00, 32'h28);
		level <= 24'h001000;
		wr(8'h20, 32'h25);
		@(posedge pclk);
		chk("cal active", 32'h1, 32'(calibration_active_out));
		// Reading status clears the scan flag, so its next rise meets the suppress check.
		apb(1'b0, 8'h04, 32'h2, 32'h2, 1'b0);
		slots(8);
		rd(8'h20, 32'h24);
		rd(8'h48, 32'h1000);
		level <= 24'h401000;
		wr(8'h20, 32'h26);
		slots(8);
		rd(8'h68, 32'h400000);
		level <= 24'hc01000;
		wr(8'h20, 32'h27);
		slots(8);
		rd(8'h88, 32'h400000);
		chk("cal active", 32'h0, 32'(calibration_active_out));
		wr(8'h34, 32'h01);
		@(posedge pclk);
		chk("cal active", 32'h0, 32'(calibration_active_out));
		slots(8);
		rd(8'h34, 32'h01);
		wr(8'h34, 32'h00);
		$display("calibration test done");
		// Random levels through every polarity and coding choice.
		for (int k = 0; k < 16; k++) begin
			raw = 24'($random(seed));
			rnd = $random(seed);
			raw[7:0] = 8'h00;
			level <= raw;
			delay <= {1'b0, rnd[2:0]};
			wr(8'h00, {29'h0, k[1], 2'h0});
			wr(8'h20, {25'h0, 3'h2, 1'b0, k[0], 2'h0});
			slots(3);
			chk("bipolar", 32'(k[0]), 32'(conv_bipolar));
			chk("physical", 32'h2, 32'(conv_physical));
			rd(8'ha0, 32'(calc(raw, 24'h1000, 24'h400000, k[0], k[1])));
		end
		$display("coding test done");
		// Averaging needs four whole scans before the scan end.
		wr(8'h00, 32'h01);
		apb(1'b0, 8'h04, 32'h0, 32'h4, 1'b0);
		chk("scan irq", 32'h0, 32'(end_of_scan_irq));
		slots(30);
		chk("scan irq", 32'h0, 32'(end_of_scan_irq));
		slots(3);
		repeat (2) @(posedge pclk);
		chk("scan irq", 32'h1, 32'(end_of_scan_irq));
		apb(1'b0, 8'h04, 32'h5, 32'h5, 1'b0);
		wr(8'h00, 32'h03);
		slots(20);
		$display("averaging test done");
		test_done();
	end
endmodule
